// ==== rtl/cppg_map.svh ====
// offsets, field positions, reset values and timing counts of the cascaded pulse timer
`ifndef CPPG_MAP_SVH
`define CPPG_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CPPG_ADDR_W        8
`define CPPG_OFS_CTRL      8'h00
`define CPPG_OFS_PW_LO     8'h04
`define CPPG_OFS_PW_HI     8'h08
`define CPPG_OFS_PER_LO    8'h0C
`define CPPG_OFS_PER_HI    8'h10
`define CPPG_OFS_COUNT     8'h14
`define CPPG_OFS_STATUS    8'h18
`define CPPG_OFS_MASK      8'h1C
`define CPPG_OFS_STATE     8'h20
`define CPPG_OFS_SYSCLK    8'h24

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CPPG_CTRL_RUN      0
`define CPPG_CTRL_MODE     1
`define CPPG_CTRL_FFI      2
`define CPPG_CTRL_LFFI     3
`define CPPG_CTRL_SEL_LSB  4
`define CPPG_CTRL_SEL_MSB  6
`define CPPG_STAT_MATCH    0
`define CPPG_STATE_FF      0
`define CPPG_STATE_RUN     1
`define CPPG_SYS_HF_EN     0
`define CPPG_SYS_LF_EN     1
`define CPPG_SYS_SEL       2

// ---------------------------------------------------------------
// source clock select codes
// ---------------------------------------------------------------
`define CPPG_SEL_HF        3'h0
`define CPPG_SEL_HF_D2     3'h1
`define CPPG_SEL_HF_D8     3'h2
`define CPPG_SEL_HF_D32    3'h3
`define CPPG_SEL_HF_D128   3'h4
`define CPPG_SEL_HF_D2048  3'h5
`define CPPG_SEL_LF        3'h6
`define CPPG_SEL_EXT       3'h7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CPPG_CMP_RST       8'h00
`define CPPG_SYSCLK_RST    3'h1
`define CPPG_MASK_RST      1'h0

// ---------------------------------------------------------------
// clock rates and timing
// ---------------------------------------------------------------
`define CPPG_PCLK_HZ       250000000
`define CPPG_HF_HZ         16000000
`define CPPG_LF_HZ         32768
`define CPPG_ACC_W         29
`define CPPG_DIV_W         11
`define CPPG_WARMUP_MIN_US 16
`define CPPG_WARMUP_MIN_CYC ((`CPPG_WARMUP_MIN_US * (`CPPG_PCLK_HZ / 1000000)))

`endif

// ==== rtl/cppg_pkg.sv ====
// types of the cascaded pulse timer
package cppg_pkg;

	// timer operating mode
	typedef enum logic {
		CPPG_MODE_PULSE,
		CPPG_MODE_WARMUP
	} cppg_mode_t;

	// apb request from the master
	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} cppg_apb_req_t;

	// system clock control outputs
	typedef struct packed {
		logic sys_clk_sel;
		logic lf_osc_en;
		logic hf_osc_en;
	} cppg_sysclk_t;

	// all state of the top module
	typedef struct packed {
		logic         run;
		cppg_mode_t   mode;
		logic         ff_init;
		logic         lo_ff_init;
		logic [2:0]   clk_sel;
		logic [15:0]  count;
		logic         ff;
		logic         pin_n;
		logic         stat;
		logic         mask;
		logic         irq;
		logic         pready;
		logic         pslverr;
		logic [31:0]  prdata;
		cppg_sysclk_t sysclk;
	} cppg_state_t;

	// state of the source tick generator
	typedef struct packed {
		logic [28:0] hf_acc;
		logic [28:0] lf_acc;
		logic [10:0] div;
		logic        ev_prev;
		logic        tick;
	} cppg_presc_t;

endpackage

// ==== rtl/cppg_cmp_reg.sv ====
// one 16-bit compare register written as two bytes
`timescale 1ns/1ps
`include "cppg_map.svh"

module cppg_cmp_reg
	import cppg_pkg::*;
#(
	parameter int BYTE_W = 8
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                wr_lo,
	input  wire logic                wr_hi,
	input  wire logic [BYTE_W-1:0]   wdata,
	output logic      [2*BYTE_W-1:0] value
);

	logic [2*BYTE_W-1:0] val_ff;
	logic [2*BYTE_W-1:0] nxt_val;

	// no shadow stage: each byte acts at once
	always_comb begin
		nxt_val = val_ff;
		if (wr_lo) begin
			nxt_val[BYTE_W-1:0] = wdata;
		end
		if (wr_hi) begin
			nxt_val[2*BYTE_W-1:BYTE_W] = wdata;
		end
	end

	// register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			val_ff <= '0;
		end else begin
			val_ff <= nxt_val;
		end
	end

	assign value = val_ff;

endmodule // cppg_cmp_reg

// ==== rtl/cppg_presc.sv ====
// source tick generator: divided high / low frequency clock or external event
`timescale 1ns/1ps
`include "cppg_map.svh"

module cppg_presc
	import cppg_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       clear,
	input  wire logic [2:0] clk_sel,
	input  wire logic       event_in,
	output logic            tick
);

	localparam logic [28:0] PCLK = 29'(`CPPG_PCLK_HZ);
	localparam logic [28:0] HF   = 29'(`CPPG_HF_HZ);
	localparam logic [28:0] LF   = 29'(`CPPG_LF_HZ);

	cppg_presc_t s_ff;
	cppg_presc_t nxt_s;
	logic        hf_tick;
	logic        lf_tick;
	logic [10:0] tap;

	// fractional accumulators give exact mean rates of both clocks
	always_comb begin
		nxt_s = s_ff;
		hf_tick = (s_ff.hf_acc + HF) >= PCLK;
		lf_tick = (s_ff.lf_acc + LF) >= PCLK;
		nxt_s.hf_acc = hf_tick ? (s_ff.hf_acc + HF - PCLK) : (s_ff.hf_acc + HF);
		nxt_s.lf_acc = lf_tick ? (s_ff.lf_acc + LF - PCLK) : (s_ff.lf_acc + LF);
		if (clear) begin
			nxt_s.div = '0;
		end else if (hf_tick) begin
			nxt_s.div = s_ff.div + 11'h001;
		end
		unique case (clk_sel)
			`CPPG_SEL_HF:       tap = 11'h000;
			`CPPG_SEL_HF_D2:    tap = 11'h001;
			`CPPG_SEL_HF_D8:    tap = 11'h007;
			`CPPG_SEL_HF_D32:   tap = 11'h01F;
			`CPPG_SEL_HF_D128:  tap = 11'h07F;
			`CPPG_SEL_HF_D2048: tap = 11'h7FF;
			default:            tap = 11'h000;
		endcase
		nxt_s.ev_prev = event_in;
		// external source counts on the falling edge
		if (clk_sel == `CPPG_SEL_EXT) begin
			nxt_s.tick = s_ff.ev_prev & ~event_in & ~clear;
		end else if (clk_sel == `CPPG_SEL_LF) begin
			nxt_s.tick = lf_tick & ~clear;
		end else begin
			nxt_s.tick = hf_tick & ((s_ff.div & tap) == tap) & ~clear;
		end
	end

	// register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign tick = s_ff.tick;

endmodule // cppg_presc

// ==== rtl/cppg_timer.sv ====
// cascaded 16-bit pulse generator and warm-up timer with apb registers
//
// Behaviour
// - two bytes cascade into one 16-bit up-counter
// - width match toggles flop, counter keeps going
// - period match toggles flop, clears, interrupts
// - flop loads initial value; reset clears it
// - pulse pin is inverse of flop
// - compares unbuffered; take effect at once
// - stop holds pin until initial value written
// - warm-up mode times oscillator stabilisation
// - warm-up compares only period upper byte
// - warm-up match interrupts and clears counter
// - 0100h gives 16 us, FF00h 4.08 ms
`timescale 1ns/1ps
`include "cppg_map.svh"

module cppg_timer
	import cppg_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire cppg_apb_req_t apb_req,
	output logic               pready,
	output logic [31:0]        prdata,
	output logic               pslverr,
	input  wire logic          lower_timer_event_input,
	output logic               pulse_output_pin_n,
	output logic               upper_timer_interrupt,
	output cppg_sysclk_t       system_clock_control
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	cppg_state_t s_ff;
	cppg_state_t nxt_s;
	logic [15:0] pulse_width;
	logic [15:0] period;
	logic        src_tick;
	logic        setup;
	logic        commit;
	logic        wr;
	logic        rd;
	logic        mapped;
	logic [31:0] rd_mux;
	logic [15:0] count_inc;
	logic        width_hit;
	logic        period_hit;
	logic        ctrl_wr;

	// ---------------------------------------------------------------
	// apb access phases
	// ---------------------------------------------------------------

	// setup cycle and completing edge
	assign setup  = apb_req.psel & ~apb_req.penable;
	assign commit = apb_req.psel & apb_req.penable & s_ff.pready;
	assign wr     = commit & apb_req.pwrite;
	assign rd     = commit & ~apb_req.pwrite;
	assign ctrl_wr = wr & (apb_req.paddr == `CPPG_OFS_CTRL);

	// ---------------------------------------------------------------
	// compare registers
	// ---------------------------------------------------------------

	// pulse width pair, low byte first by software
	cppg_cmp_reg #(
		.BYTE_W (8)
	) u_pw (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_lo   (wr & (apb_req.paddr == `CPPG_OFS_PW_LO)),
		.wr_hi   (wr & (apb_req.paddr == `CPPG_OFS_PW_HI)),
		.wdata   (apb_req.pwdata[7:0]),
		.value   (pulse_width)
	);

	// period pair, low byte first by software
	cppg_cmp_reg #(
		.BYTE_W (8)
	) u_per (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_lo   (wr & (apb_req.paddr == `CPPG_OFS_PER_LO)),
		.wr_hi   (wr & (apb_req.paddr == `CPPG_OFS_PER_HI)),
		.wdata   (apb_req.pwdata[7:0]),
		.value   (period)
	);

	// ---------------------------------------------------------------
	// source clock
	// ---------------------------------------------------------------

	// selected internal clock or external event edges
	cppg_presc u_presc (
		.pclk     (pclk),
		.presetn  (presetn),
		.clear    (~s_ff.run),
		.clk_sel  (s_ff.clk_sel),
		.event_in (lower_timer_event_input),
		.tick     (src_tick)
	);

	// ---------------------------------------------------------------
	// read multiplexer and decode
	// ---------------------------------------------------------------

	// read data for the address in the setup cycle
	always_comb begin
		rd_mux = 32'h0000_0000;
		mapped = 1'b1;
		unique case (apb_req.paddr)
			`CPPG_OFS_CTRL: begin
				rd_mux[`CPPG_CTRL_RUN]  = s_ff.run;
				rd_mux[`CPPG_CTRL_MODE] = s_ff.mode;
				rd_mux[`CPPG_CTRL_FFI]  = s_ff.ff_init;
				rd_mux[`CPPG_CTRL_LFFI] = s_ff.lo_ff_init;
				rd_mux[`CPPG_CTRL_SEL_MSB:`CPPG_CTRL_SEL_LSB] = s_ff.clk_sel;
			end
			`CPPG_OFS_PW_LO:  rd_mux[7:0] = pulse_width[7:0];
			`CPPG_OFS_PW_HI:  rd_mux[7:0] = pulse_width[15:8];
			`CPPG_OFS_PER_LO: rd_mux[7:0] = period[7:0];
			`CPPG_OFS_PER_HI: rd_mux[7:0] = period[15:8];
			`CPPG_OFS_COUNT:  rd_mux[15:0] = s_ff.count;
			`CPPG_OFS_STATUS: rd_mux[`CPPG_STAT_MATCH] = s_ff.stat;
			`CPPG_OFS_MASK:   rd_mux[`CPPG_STAT_MATCH] = s_ff.mask;
			`CPPG_OFS_STATE: begin
				rd_mux[`CPPG_STATE_FF]  = s_ff.ff;
				rd_mux[`CPPG_STATE_RUN] = s_ff.run;
			end
			`CPPG_OFS_SYSCLK: begin
				rd_mux[`CPPG_SYS_HF_EN] = s_ff.sysclk.hf_osc_en;
				rd_mux[`CPPG_SYS_LF_EN] = s_ff.sysclk.lf_osc_en;
				rd_mux[`CPPG_SYS_SEL]   = s_ff.sysclk.sys_clk_sel;
			end
			default: mapped = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// match detection
	// ---------------------------------------------------------------

	// next count and both compares on it
	always_comb begin
		count_inc  = s_ff.count + 16'h0001;
		width_hit  = (count_inc == pulse_width);
		if (s_ff.mode == CPPG_MODE_WARMUP) begin
			period_hit = (count_inc[15:8] == period[15:8]);
		end else begin
			period_hit = (count_inc == period);
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------

	// registers, counter, flop, interrupt and bus answer
	always_comb begin
		nxt_s = s_ff;

		// apb answer: ready in the first access cycle
		nxt_s.pready  = setup;
		nxt_s.pslverr = setup & ~mapped;
		if (setup & ~apb_req.pwrite) begin
			nxt_s.prdata = rd_mux;
		end

		// control writes
		if (ctrl_wr) begin
			nxt_s.run        = apb_req.pwdata[`CPPG_CTRL_RUN];
			nxt_s.mode       = cppg_mode_t'(apb_req.pwdata[`CPPG_CTRL_MODE]);
			nxt_s.ff_init    = apb_req.pwdata[`CPPG_CTRL_FFI];
			nxt_s.lo_ff_init = apb_req.pwdata[`CPPG_CTRL_LFFI];
			nxt_s.clk_sel    = apb_req.pwdata[`CPPG_CTRL_SEL_MSB:`CPPG_CTRL_SEL_LSB];
		end
		if (wr & (apb_req.paddr == `CPPG_OFS_MASK)) begin
			nxt_s.mask = apb_req.pwdata[`CPPG_STAT_MATCH];
		end
		// oscillator enables and clock select driven by software order
		if (wr & (apb_req.paddr == `CPPG_OFS_SYSCLK)) begin
			nxt_s.sysclk.hf_osc_en   = apb_req.pwdata[`CPPG_SYS_HF_EN];
			nxt_s.sysclk.lf_osc_en   = apb_req.pwdata[`CPPG_SYS_LF_EN];
			nxt_s.sysclk.sys_clk_sel = apb_req.pwdata[`CPPG_SYS_SEL];
		end

		// flop loads only while stopped, so a stopping write holds it
		if (ctrl_wr & ~s_ff.run) begin
			nxt_s.ff = apb_req.pwdata[`CPPG_CTRL_FFI];
		end

		// counting
		if (!s_ff.run) begin
			nxt_s.count = 16'h0000;
		end else if (src_tick) begin
			if (period_hit) begin
				nxt_s.count = 16'h0000;
			end else begin
				nxt_s.count = count_inc;
			end
			if (s_ff.mode == CPPG_MODE_PULSE) begin
				// both hits in one step cancel out
				nxt_s.ff = s_ff.ff ^ width_hit ^ period_hit;
			end
		end

		// stopped timer holds the pin until a control write loads the flop
		nxt_s.pin_n = ~nxt_s.ff;

		// sticky match status, set wins over read clear
		if (rd & (apb_req.paddr == `CPPG_OFS_STATUS)) begin
			nxt_s.stat = 1'b0;
		end
		if (s_ff.run & src_tick & period_hit) begin
			nxt_s.stat = 1'b1;
		end

		// level interrupt while unmasked status is set
		nxt_s.irq = nxt_s.stat & nxt_s.mask;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------

	// reset: flop cleared, pin high, stopped, pulse mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff            <= '0;
			s_ff.pin_n      <= 1'b1;
			s_ff.mask       <= `CPPG_MASK_RST;
			s_ff.sysclk     <= `CPPG_SYSCLK_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------

	// all straight from the state register
	assign pready                = s_ff.pready;
	assign prdata                = s_ff.prdata;
	assign pslverr               = s_ff.pslverr;
	assign pulse_output_pin_n    = s_ff.pin_n;
	assign upper_timer_interrupt = s_ff.irq;
	assign system_clock_control  = s_ff.sysclk;

endmodule // cppg_timer

// ==== sim/cppg_timer_props.sv ====
// port-level assertions of the cascaded pulse timer
`timescale 1ns/1ps
`include "cppg_map.svh"

module cppg_timer_props
	import cppg_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire cppg_apb_req_t apb_req,
	input  wire logic          pready,
	input  wire logic [31:0]   prdata,
	input  wire logic          pslverr,
	input  wire logic          lower_timer_event_input,
	input  wire logic          pulse_output_pin_n,
	input  wire logic          upper_timer_interrupt,
	input  wire cppg_sysclk_t  system_clock_control
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic mapped;
	logic wr_sys;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// address decode and system clock write commit
	assign mapped = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr <= `CPPG_OFS_SYSCLK;
	assign wr_sys = pready && apb_req.pwrite && apb_req.paddr == `CPPG_OFS_SYSCLK;

	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_pulse;
		pready ##1 !pready;
	endsequence

	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	property p_ready_one;
		s_setup |=> s_pulse;
	endproperty
	property p_err_map;
		s_setup ##0 !mapped |=> pslverr;
	endproperty
	property p_ok_map;
		s_setup ##0 mapped |=> !pslverr;
	endproperty
	property p_rdata_hold;
		$changed(prdata) |-> pready;
	endproperty
	property p_irq_clear;
		$fell(upper_timer_interrupt) |-> $past(pready) || $past(pready, 2);
	endproperty
	property p_sys_write;
		$changed(system_clock_control) |-> $past(wr_sys) || $past(wr_sys, 2);
	endproperty
	property p_pin_reset;
		$rose(presetn) |-> pulse_output_pin_n;
	endproperty
	property p_irq_reset;
		$rose(presetn) |-> !upper_timer_interrupt && !pready;
	endproperty

	a_ready_one: assert property (p_ready_one)
		else $error("pready not a single cycle after setup");
	a_err_map: assert property (p_err_map)
		else $error("no error on unmapped address");
	a_ok_map: assert property (p_ok_map)
		else $error("error on mapped address");
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved outside access");
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt fell without bus access");
	a_sys_write: assert property (p_sys_write)
		else $error("clock control moved without write");
	a_pin_reset: assert property (p_pin_reset)
		else $error("pulse pin low after reset");
	a_irq_reset: assert property (p_irq_reset)
		else $error("interrupt or ready high after reset");
endmodule // cppg_timer_props

bind cppg_timer cppg_timer_props u_props (
	.pclk                    (pclk),
	.presetn                 (presetn),
	.apb_req                 (apb_req),
	.pready                  (pready),
	.prdata                  (prdata),
	.pslverr                 (pslverr),
	.lower_timer_event_input (lower_timer_event_input),
	.pulse_output_pin_n      (pulse_output_pin_n),
	.upper_timer_interrupt   (upper_timer_interrupt),
	.system_clock_control    (system_clock_control)
);

// ==== sim/cppg_ev_src.sv ====
// external event source model driving the event input
`timescale 1ns/1ps

module cppg_ev_src #(
	parameter int HOLD = 8
) (
	input  wire logic       pclk,
	input  wire logic       start,
	input  wire logic [7:0] n,
	output logic            ev,
	output logic            busy
);
	// ---------------------------------------------------------------
	// pulse train, idle high
	// ---------------------------------------------------------------
	initial begin
		ev = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge pclk);
			if (start) begin
				busy <= 1'b1;
				repeat (n) begin
					ev <= 1'b0;
					repeat (HOLD) @(posedge pclk);
					ev <= 1'b1;
					repeat (HOLD) @(posedge pclk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule // cppg_ev_src

// ==== sim/test_cascaded_ppg_warmup_timer.sv ====
// self-checking bench for the cascaded pulse timer
`timescale 1ns/1ps
`include "cppg_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t act=%h exp=%h", $time, (a), (e)); end end

module test_cascaded_ppg_warmup_timer;
	import cppg_pkg::*;

	logic          pclk;
	logic          presetn;
	cppg_apb_req_t req;
	logic          pready;
	logic [31:0]   prdata;
	logic          pslverr;
	logic          ev;
	logic          ev_busy;
	logic          ev_go;
	logic [7:0]    ev_n;
	logic          pin_n;
	logic          irq;
	cppg_sysclk_t  sysclk;
	logic [31:0]   rdat;
	logic          rerr;
	int            n_fail;
	int            checked;
	int            k;

	cppg_timer dut (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.apb_req                 (req),
		.pready                  (pready),
		.prdata                  (prdata),
		.pslverr                 (pslverr),
		.lower_timer_event_input (ev),
		.pulse_output_pin_n      (pin_n),
		.upper_timer_interrupt   (irq),
		.system_clock_control    (sysclk)
	);

	cppg_ev_src u_ev (
		.pclk  (pclk),
		.start (ev_go),
		.n     (ev_n),
		.ev    (ev),
		.busy  (ev_busy)
	);

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_fail++;
			print_verdict();
		end
		rdat = prdata;
		rerr = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask

	// send n event pulses and wait for the train to end
	task automatic pulses(input logic [7:0] n);
		int i;
		@(posedge pclk);
		ev_n <= n;
		ev_go <= 1'b1;
		@(posedge pclk);
		ev_go <= 1'b0;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (ev_busy && i < 2000);
		if (i >= 2000) begin
			n_fail++;
			print_verdict();
		end
	endtask

	// ---------------------------------------------------------------
	// clock, reset and tests
	// ---------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		req = '0;
		ev_go = 1'b0;
		ev_n = 8'h00;
		n_fail = 0;
		checked = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and an unmapped access
		`CHK(pin_n, 1'b1)
		rd_chk(`CPPG_OFS_STATE, 32'h0);
		rd_chk(`CPPG_OFS_SYSCLK, 32'h1);
		rd_chk(`CPPG_OFS_MASK, 32'h0);
		xfer(1'b0, 8'h40, 32'h0);
		`CHK(rerr, 1'b1)
		$display("reset test done");
		// pulse mode on external events: width 2, period 5
		xfer(1'b1, `CPPG_OFS_PW_LO, 32'h2);
		xfer(1'b1, `CPPG_OFS_PW_HI, 32'h0);
		xfer(1'b1, `CPPG_OFS_PER_LO, 32'h5);
		xfer(1'b1, `CPPG_OFS_PER_HI, 32'h0);
		xfer(1'b1, `CPPG_OFS_MASK, 32'h1);
		xfer(1'b1, `CPPG_OFS_CTRL, 32'h71);
		pulses(8'h02);
		`CHK(pin_n, 1'b0)
		rd_chk(`CPPG_OFS_COUNT, 32'h2);
		pulses(8'h03);
		`CHK(pin_n, 1'b1)
		`CHK(irq, 1'b1)
		rd_chk(`CPPG_OFS_COUNT, 32'h0);
		xfer(1'b1, `CPPG_OFS_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		xfer(1'b1, `CPPG_OFS_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b1)
		rd_chk(`CPPG_OFS_STATUS, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		rd_chk(`CPPG_OFS_STATUS, 32'h0);
		$display("pulse test done");
		// stop holds the pin, later initial-value writes load it
		xfer(1'b1, `CPPG_OFS_CTRL, 32'h71);
		pulses(8'h02);
		xfer(1'b1, `CPPG_OFS_CTRL, 32'h70);
		repeat (2) @(posedge pclk);
		`CHK(pin_n, 1'b0)
		rd_chk(`CPPG_OFS_COUNT, 32'h0);
		xfer(1'b1, `CPPG_OFS_CTRL, 32'h74);
		rd_chk(`CPPG_OFS_STATE, 32'h1);
		`CHK(pin_n, 1'b0)
		xfer(1'b1, `CPPG_OFS_CTRL, 32'h70);
		repeat (2) @(posedge pclk);
		`CHK(pin_n, 1'b1)
		$display("stop test done");
		// warm-up on the fast clock, low period byte ignored
		xfer(1'b1, `CPPG_OFS_SYSCLK, 32'h3);
		xfer(1'b1, `CPPG_OFS_PER_LO, 32'hFF);
		xfer(1'b1, `CPPG_OFS_PER_HI, 32'h1);
		xfer(1'b1, `CPPG_OFS_CTRL, 32'h03);
		k = 0;
		while (irq !== 1'b1 && k < 5000) begin
			@(posedge pclk);
			k++;
		end
		`CHK(k >= 3980 && k <= 4020, 1'b1)
		`CHK(pin_n, 1'b1)
		xfer(1'b1, `CPPG_OFS_CTRL, 32'h02);
		rd_chk(`CPPG_OFS_STATUS, 32'h1);
		rd_chk(`CPPG_OFS_COUNT, 32'h0);
		xfer(1'b1, `CPPG_OFS_SYSCLK, 32'h7);
		xfer(1'b1, `CPPG_OFS_SYSCLK, 32'h6);
		repeat (2) @(posedge pclk);
		`CHK(sysclk, 3'h6)
		// back to the fast clock: enable, deselect, disable slow
		xfer(1'b1, `CPPG_OFS_SYSCLK, 32'h7);
		xfer(1'b1, `CPPG_OFS_SYSCLK, 32'h3);
		xfer(1'b1, `CPPG_OFS_SYSCLK, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK(sysclk, 3'h1)
		$display("warm-up test done");
		print_verdict();
	end
endmodule // test_cascaded_ppg_warmup_timer
